// file: rtl/diag_ctl.sv
// Controller end: AXI4-Lite registers driving output bits, reading fault flags
module diag_ctl #(
    parameter int HOLD_CYC = diag_pkg::HOLD_CYC,
    parameter int TMR_W = diag_pkg::TMR_W
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    diag_if.ctl link,
    input wire logic [diag_pkg::ADDR_W-1:0] awaddr_i,
    input wire logic awvalid_i,
    output logic awready_o,
    input wire logic [31:0] wdata_i,
    input wire logic [3:0] wstrb_i,
    input wire logic wvalid_i,
    output logic wready_o,
    output logic [1:0] bresp_o,
    output logic bvalid_o,
    input wire logic bready_i,
    input wire logic [diag_pkg::ADDR_W-1:0] araddr_i,
    input wire logic arvalid_i,
    output logic arready_o,
    output logic [31:0] rdata_o,
    output logic [1:0] rresp_o,
    output logic rvalid_o,
    input wire logic rready_i,
    output logic irq_o
);
    localparam int N = diag_pkg::NPTS;
    localparam int IW = diag_pkg::IRQ_W;

    if (HOLD_CYC < 1 || HOLD_CYC >= 2 ** TMR_W)
    begin : g_bad_hold
        $error("diag_ctl: HOLD_CYC does not fit TMR_W");
    end

    typedef struct packed {
        logic aw_held;
        logic [diag_pkg::ADDR_W-1:0] awaddr;
        logic w_held;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [N-1:0] cmd;
        logic [N-1:0] prev_flag;
        logic [N-1:0] blk;
        logic [TMR_W-1:0] hold;
        logic [IW-1:0] ist;
        logic [IW-1:0] ien;
        logic irq;
    } ctl_st_t;

    ctl_st_t st_ff;
    ctl_st_t nxt_st;

    // Byte-lane merge of a write into a word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        for (int b = 0; b < 4; b++)
        begin
            merge[8*b +: 8] = strb[b] ? nw[8*b +: 8] : old[8*b +: 8];
        end
    endfunction

    always_comb
    begin
        logic [N-1:0] fr;
        logic [N-1:0] ff;
        logic [31:0] nw;
        logic [IW-1:0] clr;
        fr = link.fault_flag & ~st_ff.prev_flag;
        ff = ~link.fault_flag & st_ff.prev_flag;
        nw = '0;
        clr = '0;
        nxt_st = st_ff;
        nxt_st.prev_flag = link.fault_flag;
        // Holdoff: faulted points may not be turned on again for 2 s
        if (|fr)
        begin
            nxt_st.hold = TMR_W'(HOLD_CYC);
            nxt_st.blk = st_ff.blk | fr;
        end
        else if (st_ff.hold != '0)
        begin
            nxt_st.hold = st_ff.hold - TMR_W'(1);
        end
        else
        begin
            nxt_st.blk = '0;
        end
        // Address and data taken in either order
        if (awvalid_i && st_ff.awready)
        begin
            nxt_st.aw_held = 1'b1;
            nxt_st.awaddr = awaddr_i;
        end
        if (wvalid_i && st_ff.wready)
        begin
            nxt_st.w_held = 1'b1;
            nxt_st.wdata = wdata_i;
            nxt_st.wstrb = wstrb_i;
        end
        if (st_ff.bvalid && bready_i)
        begin
            nxt_st.bvalid = 1'b0;
        end
        // Write once both halves are held
        if (st_ff.aw_held && st_ff.w_held && !st_ff.bvalid)
        begin
            nxt_st.aw_held = 1'b0;
            nxt_st.w_held = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = diag_pkg::RESP_OKAY;
            unique case (st_ff.awaddr)
                diag_pkg::OUT_CMD_OFS:
                begin
                    // Rising bits on blocked points keep their old value
                    nw = merge(st_ff.cmd, st_ff.wdata, st_ff.wstrb);
                    nxt_st.cmd = nw & ~(st_ff.blk & ~st_ff.cmd);
                end
                diag_pkg::IRQ_CLR_OFS: clr = st_ff.wdata[IW-1:0];
                diag_pkg::IRQ_EN_OFS: nxt_st.ien = st_ff.wdata[IW-1:0];
                diag_pkg::FAULT_OFS, diag_pkg::IRQ_STAT_OFS, diag_pkg::MODE_OFS: ;
                default: nxt_st.bresp = diag_pkg::RESP_DECERR;
            endcase
        end
        nxt_st.awready = !nxt_st.aw_held && !nxt_st.bvalid;
        nxt_st.wready = !nxt_st.w_held && !nxt_st.bvalid;
        // Read path, one read at a time
        if (st_ff.rvalid && rready_i)
        begin
            nxt_st.rvalid = 1'b0;
        end
        if (arvalid_i && st_ff.arready)
        begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp = diag_pkg::RESP_OKAY;
            nxt_st.rdata = '0;
            unique case (araddr_i)
                diag_pkg::OUT_CMD_OFS: nxt_st.rdata = st_ff.cmd;
                diag_pkg::FAULT_OFS: nxt_st.rdata = link.fault_flag;
                diag_pkg::IRQ_STAT_OFS: nxt_st.rdata[IW-1:0] = st_ff.ist;
                diag_pkg::IRQ_EN_OFS: nxt_st.rdata[IW-1:0] = st_ff.ien;
                diag_pkg::MODE_OFS: nxt_st.rdata[0] = link.report_mode;
                diag_pkg::IRQ_CLR_OFS: ;
                default: nxt_st.rresp = diag_pkg::RESP_DECERR;
            endcase
        end
        nxt_st.arready = !nxt_st.rvalid;
        // Sticky events, a new event wins over the clear
        nxt_st.ist = st_ff.ist & ~clr;
        nxt_st.ist[diag_pkg::IRQ_FAULT_SET] = nxt_st.ist[diag_pkg::IRQ_FAULT_SET] | (|fr);
        nxt_st.ist[diag_pkg::IRQ_FAULT_CLR] = nxt_st.ist[diag_pkg::IRQ_FAULT_CLR] | (|ff);
        nxt_st.irq = |(nxt_st.ist & nxt_st.ien);
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_ff <= '0;
            st_ff.cmd <= diag_pkg::OUT_CMD_RST;
            st_ff.ien <= diag_pkg::IRQ_EN_RST;
            st_ff.awready <= 1'b1;
            st_ff.wready <= 1'b1;
            st_ff.arready <= 1'b1;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from the state register
    assign awready_o = st_ff.awready;
    assign wready_o = st_ff.wready;
    assign bvalid_o = st_ff.bvalid;
    assign bresp_o = st_ff.bresp;
    assign arready_o = st_ff.arready;
    assign rvalid_o = st_ff.rvalid;
    assign rresp_o = st_ff.rresp;
    assign rdata_o = st_ff.rdata;
    assign irq_o = st_ff.irq;
    assign link.out_cmd = st_ff.cmd;
endmodule

// file: rtl/diag_if.sv
// Link between the output module and its controller
interface diag_if;
    logic [diag_pkg::NPTS-1:0] out_cmd;
    logic [diag_pkg::NPTS-1:0] fault_flag;
    logic report_mode;
    modport dev (input out_cmd, output fault_flag, output report_mode);
    modport ctl (output out_cmd, input fault_flag, input report_mode);
endinterface

// file: rtl/diag_out_dev.sv
// Diagnostic 32-point output module: arm, trip, holdoff and fault flags
// Operation
// - 32 points, four groups of eight
// - Strap selects fault flags returned or not
// - Fault disarms point, sets its flag
// - Only off then on rearms a point
// - Turn-on ignored before 2 s holdoff
// - Flag clears after holdoff once commanded low
// - Non-reporting mode disarms, returns no flags
// - Controller recycles on points after power return
// - Controller clears faults after power return
// - Load at or below 100 mA trips
// - Open load held 1 ms trips
// - Over-current right after turn-on trips at once
// - Over-current held 1 ms trips
// - Over-temperature trips point, sets flag
// - Unwired point turned on: open load, blink
// - Remove fault cause before restarting point
module diag_out_dev #(
    parameter int FILT_CYC = diag_pkg::FILT_CYC,
    parameter int HOLD_CYC = diag_pkg::HOLD_CYC,
    parameter int BLINK_CYC = diag_pkg::BLINK_CYC,
    parameter int TMR_W = diag_pkg::TMR_W
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    diag_if.dev link,
    input wire logic report_sel_i,
    input wire logic [diag_pkg::NPTS-1:0] open_load_i,
    input wire logic [diag_pkg::NPTS-1:0] over_cur_i,
    input wire logic [diag_pkg::NPTS-1:0] over_temp_i,
    input wire logic [diag_pkg::NGRP-1:0] over_volt_i,
    output logic [diag_pkg::NPTS-1:0] drive_o,
    output logic active_led_o
);
    localparam int N = diag_pkg::NPTS;
    localparam int G = diag_pkg::NGRP;
    // Synchronised vector: open load, over-current, over-temp, over-volt, strap
    localparam int SW = 3 * N + G + 1;
    localparam int OL_LSB = 0;
    localparam int OC_LSB = N;
    localparam int OT_LSB = 2 * N;
    localparam int OV_LSB = 3 * N;
    localparam int MODE_BIT = 3 * N + G;
    localparam logic [TMR_W-1:0] HOLD_T = TMR_W'(HOLD_CYC);
    localparam logic [TMR_W-1:0] FILT_T = TMR_W'(FILT_CYC - 1);
    localparam logic [TMR_W-1:0] BLINK_T = TMR_W'(BLINK_CYC - 1);

    // Refuse counts the timers cannot hold
    if (HOLD_CYC >= 2 ** TMR_W || FILT_CYC < 1 || BLINK_CYC < 1
        || BLINK_CYC >= 2 ** TMR_W || FILT_CYC >= HOLD_CYC || TMR_W > 31)
    begin : g_bad_count
        $error("diag_out_dev: timer counts do not fit TMR_W");
    end

    typedef struct packed {
        logic [SW-1:0] s1;
        logic [SW-1:0] s2;
        logic [SW-1:0] s3;
        logic [SW-1:0] flt;
        logic [N-1:0] armed;
        logic [N-1:0] flag;
        logic [N-1:0] rep;
        logic [N-1:0] prev_cmd;
        logic [N-1:0] drive;
        logic [N-1:0] fresh;
        logic [N-1:0][TMR_W-1:0] tmr;
        logic [TMR_W-1:0] blink;
        logic led;
    } dev_st_t;

    dev_st_t st_ff;
    dev_st_t nxt_st;
    logic [SW-1:0] raw;

    // Timer step, saturating at the top
    function automatic logic [TMR_W-1:0] tick(input logic [TMR_W-1:0] v);
        tick = (v == '1) ? v : v + TMR_W'(1);
    endfunction

    // Field indications gathered for the synchroniser
    assign raw = {report_sel_i, over_volt_i, over_temp_i, over_cur_i, open_load_i};

    // Next state of every point
    always_comb
    begin
        logic cmd;
        logic rise;
        logic ol;
        logic oc;
        logic ot;
        logic ov;
        logic trip;
        logic expired;
        cmd = 1'b0;
        rise = 1'b0;
        ol = 1'b0;
        oc = 1'b0;
        ot = 1'b0;
        ov = 1'b0;
        trip = 1'b0;
        expired = 1'b0;
        nxt_st = st_ff;
        // Three-stage synchroniser, value taken once stages two and three agree
        nxt_st.s1 = raw;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        nxt_st.flt = (st_ff.s2 & ~(st_ff.s2 ^ st_ff.s3))
            | (st_ff.flt & (st_ff.s2 ^ st_ff.s3));
        // Each point runs on its own; groups only share a supply monitor
        for (int i = 0; i < N; i++)
        begin
            cmd = link.out_cmd[i];
            rise = cmd & ~st_ff.prev_cmd[i];
            ol = st_ff.flt[OL_LSB + i];
            oc = st_ff.flt[OC_LSB + i];
            ot = st_ff.flt[OT_LSB + i];
            ov = st_ff.flt[OV_LSB + i / diag_pkg::GRP_SIZE];
            expired = (st_ff.tmr[i] == HOLD_T);
            trip = 1'b0;
            nxt_st.prev_cmd[i] = cmd;
            if (st_ff.armed[i])
            begin
                // Immediate trips while the point drives
                if (st_ff.drive[i] && (ot || ov))
                begin
                    trip = 1'b1;
                end
                // Over-current in the first cycle after turn-on
                if (st_ff.fresh[i] && oc)
                begin
                    trip = 1'b1;
                end
                // Persistent open load or over-current
                if (st_ff.drive[i] && (ol || oc))
                begin
                    nxt_st.tmr[i] = tick(st_ff.tmr[i]);
                    if (st_ff.tmr[i] >= FILT_T)
                    begin
                        trip = 1'b1;
                    end
                end
                else
                begin
                    nxt_st.tmr[i] = '0;
                end
                if (trip)
                begin
                    // Disarm on its own and latch the fault
                    nxt_st.armed[i] = 1'b0;
                    nxt_st.flag[i] = 1'b1;
                    nxt_st.tmr[i] = '0;
                end
            end
            else
            begin
                // Holdoff runs from the fault
                if (!expired)
                begin
                    nxt_st.tmr[i] = tick(st_ff.tmr[i]);
                end
                if (expired && rise)
                begin
                    // Off-then-on after holdoff rearms; early edges are dropped
                    nxt_st.armed[i] = 1'b1;
                    nxt_st.flag[i] = 1'b0;
                    nxt_st.tmr[i] = '0;
                end
                else if (expired && !cmd)
                begin
                    nxt_st.flag[i] = 1'b0;
                end
            end
            nxt_st.drive[i] = nxt_st.armed[i] & cmd;
            nxt_st.fresh[i] = nxt_st.drive[i] & ~st_ff.drive[i];
        end
        // Flags reach the controller only in reporting mode
        nxt_st.rep = nxt_st.flt[MODE_BIT] ? nxt_st.flag : '0;
        // Active light steady, blinking while any fault is latched
        if (|st_ff.flag)
        begin
            if (st_ff.blink >= BLINK_T)
            begin
                nxt_st.blink = '0;
                nxt_st.led = ~st_ff.led;
            end
            else
            begin
                nxt_st.blink = st_ff.blink + TMR_W'(1);
            end
        end
        else
        begin
            nxt_st.blink = '0;
            nxt_st.led = 1'b1;
        end
    end

    // State register; all points armed and off after reset
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_ff <= '0;
            st_ff.armed <= '1;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from the state register
    assign drive_o = st_ff.drive;
    assign active_led_o = st_ff.led;
    assign link.fault_flag = st_ff.rep;
    assign link.report_mode = st_ff.flt[MODE_BIT];
endmodule

// file: rtl/diag_pkg.sv
// Shared constants for the diagnostic output block and its controller
package diag_pkg;
    // Point layout
    localparam int NPTS = 32;
    localparam int GRP_SIZE = 8;
    localparam int NGRP = NPTS / GRP_SIZE;
    // Clock rate
    localparam int CLK_HZ = 100_000_000;
    // Open-load and over-current persistence, least time 1 ms
    localparam int FILT_US = 1000;
    localparam int FILT_CYC = FILT_US * (CLK_HZ / 1_000_000);
    // Holdoff after a fault, least time 2 s
    localparam int HOLD_MS = 2000;
    localparam int HOLD_CYC = HOLD_MS * (CLK_HZ / 1000);
    // Half period of the active light blink
    localparam int BLINK_MS = 250;
    localparam int BLINK_CYC = BLINK_MS * (CLK_HZ / 1000);
    // Timer width able to hold the holdoff count
    localparam int TMR_W = 28;
    // Controller register offsets
    localparam int ADDR_W = 8;
    localparam logic [7:0] OUT_CMD_OFS = 8'h00;
    localparam logic [7:0] FAULT_OFS = 8'h04;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
    localparam logic [7:0] IRQ_CLR_OFS = 8'h0c;
    localparam logic [7:0] IRQ_EN_OFS = 8'h10;
    localparam logic [7:0] MODE_OFS = 8'h14;
    // Interrupt bit positions
    localparam int IRQ_W = 2;
    localparam int IRQ_FAULT_SET = 0;
    localparam int IRQ_FAULT_CLR = 1;
    // Reset values
    localparam logic [31:0] OUT_CMD_RST = 32'h0000_0000;
    localparam logic [IRQ_W-1:0] IRQ_EN_RST = 2'h0;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// file: tb/diag_sva.sv
// Assertions on the link, the point drives and the field indications
module diag_sva #(
    parameter int FILT_CYC = diag_pkg::FILT_CYC,
    parameter int HOLD_CYC = diag_pkg::HOLD_CYC
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [31:0] out_cmd_i,
    input wire logic [31:0] fault_flag_i,
    input wire logic report_mode_i,
    input wire logic [31:0] drive_i,
    input wire logic [31:0] open_load_i,
    input wire logic [31:0] over_temp_i,
    input wire logic [3:0] over_volt_i
);
    timeunit 1ns;
    timeprecision 1ns;
    // Age counters stop just past the clearing bound
    localparam int AGE_TOP = HOLD_CYC + 8;
    logic [31:0] ov_pts;
    logic [31:0] flag_q;
    int ol_cnt;
    int hc [32];

    default clocking @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);

    // Group supply fault spread to its eight points
    always_comb
    begin
        for (int i = 0; i < 32; i++)
            ov_pts[i] = over_volt_i[i / 8];
    end

    // Open-load run length and age of each point's latest fault
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ol_cnt <= 0;
            flag_q <= '0;
            for (int i = 0; i < 32; i++)
                hc[i] <= 0;
        end
        else
        begin
            ol_cnt <= (|(open_load_i & drive_i)) ? ol_cnt + 1 : 0;
            flag_q <= fault_flag_i;
            for (int i = 0; i < 32; i++)
            begin
                if (fault_flag_i[i] && !flag_q[i])
                    hc[i] <= 0;
                else if (hc[i] < AGE_TOP)
                    hc[i] <= hc[i] + 1;
            end
        end
    end

    a_drive_needs_cmd:
    assert property ((drive_i & ~$past(out_cmd_i)) == '0) else $error("drive without command");
    a_flag_drive_off:
    assert property ((drive_i & fault_flag_i) == '0) else $error("faulted point driven");
    a_quiet_no_flags:
    assert property (!report_mode_i |-> fault_flag_i == '0) else $error("flag in quiet mode");
    a_temp_trips:
    assert property (not ((|(over_temp_i & drive_i)) [*7])) else $error("no temp trip");
    a_volt_trips:
    assert property (not ((|(ov_pts & drive_i)) [*7])) else $error("no volt trip");
    a_open_load_bound:
    assert property (ol_cnt <= FILT_CYC + 8) else $error("open load not tripped");
    // Per-point holdoff and flag clearing
    for (genvar i = 0; i < 32; i++)
    begin
        a_holdoff_kept:
        assert property ($fell(fault_flag_i[i]) |-> hc[i] >= HOLD_CYC - 3)
            else $error("flag cleared early");
        a_flag_clears:
        assert property (fault_flag_i[i] && !out_cmd_i[i] && !$past(out_cmd_i[i]) |->
            hc[i] <= HOLD_CYC + 6) else $error("flag not cleared");
    end
endmodule

// file: tb/testbench.sv
// Bench: controller and output module joined over the link
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int FILT = 20;
    localparam int HOLD = 60;
    typedef struct {
        logic w;
        logic [7:0] a;
        logic [31:0] d;
        logic [3:0] s;
        logic [31:0] e;
        logic [1:0] r;
    } row_t;
    logic mclk_i, rst_n_i, sel, awvalid, wvalid, bready, arvalid, rready, led, irq;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rv, ol, oc, ot, drv;
    logic [3:0] wstrb, ov;
    logic [1:0] bresp, rresp, rr;
    logic [1:0] seen;
    int errors, checked, cyc;
    row_t rows [12] = '{
        '{1'h0, diag_pkg::OUT_CMD_OFS, 32'h0, 4'hf, 32'h0, diag_pkg::RESP_OKAY},
        '{1'h0, diag_pkg::FAULT_OFS, 32'h0, 4'hf, 32'h0, diag_pkg::RESP_OKAY},
        '{1'h0, diag_pkg::IRQ_STAT_OFS, 32'h0, 4'hf, 32'h0, diag_pkg::RESP_OKAY},
        '{1'h0, diag_pkg::IRQ_EN_OFS, 32'h0, 4'hf, 32'h0, diag_pkg::RESP_OKAY},
        '{1'h0, diag_pkg::MODE_OFS, 32'h0, 4'hf, 32'h1, diag_pkg::RESP_OKAY},
        '{1'h1, diag_pkg::IRQ_CLR_OFS, 32'h3, 4'hf, 32'h0, diag_pkg::RESP_OKAY},
        '{1'h1, diag_pkg::FAULT_OFS, 32'hffff_ffff, 4'hf, 32'h0, diag_pkg::RESP_OKAY},
        '{1'h1, 8'h18, 32'h1, 4'hf, 32'h0, diag_pkg::RESP_DECERR},
        '{1'h1, diag_pkg::IRQ_EN_OFS, 32'h3, 4'hf, 32'h3, diag_pkg::RESP_OKAY},
        '{1'h1, diag_pkg::OUT_CMD_OFS, 32'hffff_ffff, 4'h2, 32'h0000_ff00, diag_pkg::RESP_OKAY},
        '{1'h1, diag_pkg::OUT_CMD_OFS, 32'h8000_0001, 4'hf, 32'h8000_0001, diag_pkg::RESP_OKAY},
        '{1'h1, diag_pkg::OUT_CMD_OFS, 32'h0, 4'hf, 32'h0, diag_pkg::RESP_OKAY}};

    diag_if diag_if_i ();
    diag_out_dev #(.FILT_CYC(FILT), .HOLD_CYC(HOLD), .BLINK_CYC(4)) diag_out_dev_i (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .link(diag_if_i), .report_sel_i(sel),
        .open_load_i(ol), .over_cur_i(oc), .over_temp_i(ot), .over_volt_i(ov),
        .drive_o(drv), .active_led_o(led));
    diag_ctl #(.HOLD_CYC(HOLD)) diag_ctl_i (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .link(diag_if_i), .awaddr_i(awaddr),
        .awvalid_i(awvalid), .awready_o(awready), .wdata_i(wdata), .wstrb_i(wstrb),
        .wvalid_i(wvalid), .wready_o(wready), .bresp_o(bresp), .bvalid_o(bvalid),
        .bready_i(bready), .araddr_i(araddr), .arvalid_i(arvalid), .arready_o(arready),
        .rdata_o(rdata), .rresp_o(rresp), .rvalid_o(rvalid), .rready_i(rready), .irq_o(irq));
    diag_sva #(.FILT_CYC(FILT), .HOLD_CYC(HOLD)) diag_sva_i (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .out_cmd_i(diag_if_i.out_cmd),
        .fault_flag_i(diag_if_i.fault_flag), .report_mode_i(diag_if_i.report_mode),
        .drive_i(drv), .open_load_i(ol), .over_temp_i(ot), .over_volt_i(ov));

    // Clock
    initial
    begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    // Hang guard
    always @(posedge mclk_i)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            errors++;
            $display("Error at %0t: timeout", $time);
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask

    // Write: each channel released once taken, then wait for the response
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] r);
        logic aw;
        logic w;
        aw = 1'b1;
        w = 1'b1;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (aw || w)
        begin
            @(posedge mclk_i);
            if (awready === 1'b1)
                aw = 1'b0;
            if (wready === 1'b1)
                w = 1'b0;
            awvalid <= aw;
            wvalid <= w;
        end
        do @(posedge mclk_i); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
        @(posedge mclk_i);
    endtask

    // Read: address until taken, data when valid
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge mclk_i); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge mclk_i); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge mclk_i);
    endtask

    task automatic put(input logic [31:0] d);
        wr(diag_pkg::OUT_CMD_OFS, d, 4'hf, rr);
    endtask

    task automatic get(input logic [7:0] a, input logic [31:0] e);
        rd(a, rv, rr);
        chk(rv, e, "reg");
    endtask

    task automatic run_row(input row_t x);
        logic [31:0] d;
        logic [1:0] r;
        if (x.w)
        begin
            wr(x.a, x.d, x.s, r);
            chk(r, x.r, "bresp");
        end
        rd(x.a, d, r);
        chk(r, x.r, "rresp");
        if (r === diag_pkg::RESP_OKAY)
            chk(d, x.e, "rdata");
        if (x.a == diag_pkg::OUT_CMD_OFS)
            chk(drv, x.e, "drive");
    endtask

    initial
    begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} <= '0;
        {ol, oc, ot, ov} <= '0;
        sel <= 1'b1;
        rst_n_i <= 1'b0;
        repeat (5) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        repeat (5) @(posedge mclk_i);
        foreach (rows[i]) run_row(rows[i]);
        chk({31'h0, led}, 32'h1, "led steady");
        $display("test registers done");
        // Over-temperature trip, early rearm refused, flag clear, rearm
        put(32'h8);
        ot <= 32'h8;
        repeat (8) @(posedge mclk_i);
        chk(drv, 32'h0, "temp trip");
        chk({31'h0, irq}, 32'h1, "irq set");
        get(diag_pkg::FAULT_OFS, 32'h8);
        ot <= 32'h0;
        put(32'h0);
        put(32'h8);
        chk(drv, 32'h0, "early rearm");
        get(diag_pkg::OUT_CMD_OFS, 32'h0);
        repeat (HOLD) @(posedge mclk_i);
        get(diag_pkg::FAULT_OFS, 32'h0);
        get(diag_pkg::IRQ_STAT_OFS, 32'h3);
        wr(diag_pkg::IRQ_CLR_OFS, 32'h3, 4'hf, rr);
        get(diag_pkg::IRQ_STAT_OFS, 32'h0);
        chk({31'h0, irq}, 32'h0, "irq clear");
        put(32'h8);
        chk(drv, 32'h8, "rearm");
        $display("test temperature done");
        // Open load must persist before the trip
        put(32'h28);
        ol <= 32'h20;
        repeat (FILT - 4) @(posedge mclk_i);
        chk(drv, 32'h28, "open load early");
        repeat (12) @(posedge mclk_i);
        chk(drv, 32'h8, "open load trip");
        get(diag_pkg::FAULT_OFS, 32'h20);
        ol <= 32'h0;
        seen = 2'h0;
        repeat (10)
        begin
            @(posedge mclk_i);
            seen = seen | {led, ~led};
        end
        chk({30'h0, seen}, 32'h3, "led blink");
        $display("test open load done");
        // Over-current present at turn-on trips at once
        oc <= 32'h80;
        repeat (4) @(posedge mclk_i);
        put(32'ha8);
        repeat (3) @(posedge mclk_i);
        chk(drv, 32'h8, "current at turn-on");
        get(diag_pkg::FAULT_OFS, 32'ha0);
        oc <= 32'h0;
        $display("test current done");
        // Group supply over-voltage
        put(32'h0001_0008);
        ov <= 4'h4;
        repeat (8) @(posedge mclk_i);
        chk(drv, 32'h8, "volt trip");
        chk({31'h0, diag_if_i.fault_flag[16]}, 32'h1, "volt flag");
        ov <= 4'h0;
        $display("test voltage done");
        // Reset into quiet mode: trip without flags, rearm after holdoff
        sel <= 1'b0;
        rst_n_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        chk(drv, 32'h0, "reset drive");
        chk({31'h0, led}, 32'h0, "reset led");
        rst_n_i <= 1'b1;
        repeat (6) @(posedge mclk_i);
        get(diag_pkg::MODE_OFS, 32'h0);
        put(32'h1);
        ot <= 32'h1;
        repeat (8) @(posedge mclk_i);
        chk(drv, 32'h0, "quiet trip");
        get(diag_pkg::FAULT_OFS, 32'h0);
        ot <= 32'h0;
        put(32'h0);
        put(32'h1);
        chk(drv, 32'h0, "quiet early");
        repeat (HOLD) @(posedge mclk_i);
        put(32'h0);
        put(32'h1);
        chk(drv, 32'h1, "quiet rearm");
        $display("test quiet mode done");
        end_sim();
    end
endmodule
